// File: hdl/igp_pkg.sv
/*
 Constants, types and timing counts for the inverter gate controller.
 Assumes a 250 MHz system clock and an open-drain fault line with an external pull-up.
*/
package igp_pkg;
    localparam int CLK_MHZ = 250;
    localparam int DEAD_NS = 2000;
    localparam int MIN_ON_NS = 500;
    localparam int MIN_OFF_NS = 1500;
    localparam int MIN_OFF_HI_NS = 3000;
    localparam int FAULT_MIN_NS = 40000;
    // Least times round up to whole cycles
    localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int MIN_ON_CYC = (MIN_ON_NS * CLK_MHZ + 999) / 1000;
    localparam int MIN_OFF_CYC = (MIN_OFF_NS * CLK_MHZ + 999) / 1000;
    localparam int MIN_OFF_HI_CYC = (MIN_OFF_HI_NS * CLK_MHZ + 999) / 1000;
    localparam int FAULT_MIN_CYC = (FAULT_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 16;
    localparam int PHASES = 3;

    // One phase command pair
    typedef struct packed {
        logic high;
        logic low;
    } igp_leg_t;

    typedef enum logic [1:0] {
        LEG_OFF,
        LEG_DEAD,
        LEG_HIGH,
        LEG_LOW
    } igp_leg_st_t;
endpackage : igp_pkg

// File: hdl/igp_leg.sv
/*
 One phase leg shaper: turns a requested drive into high/low gate commands.
 Assumes requests are synchronous to CLOCK and that the parent handles faults.
*/
`timescale 1ns/1ns
module igp_leg
    import igp_pkg::*;
#(
    parameter int DEAD = DEAD_CYC,
    parameter int MIN_ON = MIN_ON_CYC,
    parameter int MIN_OFF = MIN_OFF_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic req_high,
    input wire logic req_low,
    input wire logic hold_off,
    input wire logic hi_current,
    output igp_leg_t leg
);
    igp_leg_st_t st_ff, nxt_st;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [CNT_W-1:0] off_min;
    logic hi_want, lo_want;

    // Request decode and off-time choice
    always_comb begin
        hi_want = req_high && !req_low && !hold_off;
        lo_want = req_low && !req_high && !hold_off;
        off_min = hi_current ? CNT_W'(MIN_OFF_HI_CYC) : CNT_W'(MIN_OFF);
    end

    // Next state: on-phases last at least MIN_ON unless held off, off dwell lasts at least dead time
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = (cnt_ff != '0) ? cnt_ff - CNT_W'(1) : cnt_ff;
        case (st_ff)
            LEG_OFF: begin
                if (hold_off) begin
                    nxt_cnt = '0;
                end else if ((hi_want || lo_want) && cnt_ff == '0) begin
                    nxt_st = hi_want ? LEG_HIGH : LEG_LOW;
                    nxt_cnt = CNT_W'(MIN_ON);
                end
            end
            LEG_HIGH, LEG_LOW: begin
                if (hold_off) begin
                    nxt_st = LEG_DEAD;
                    nxt_cnt = CNT_W'(DEAD);
                end else if (cnt_ff == '0 && !((st_ff == LEG_HIGH) ? hi_want : lo_want)) begin
                    nxt_st = LEG_DEAD;
                    nxt_cnt = (off_min > CNT_W'(DEAD)) ? off_min : CNT_W'(DEAD);
                end
            end
            LEG_DEAD: begin
                if (cnt_ff == '0) begin
                    nxt_st = LEG_OFF;
                end
            end
            default: begin
                nxt_st = LEG_OFF;
                nxt_cnt = '0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_ff <= LEG_OFF;
            cnt_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
        end
    end

    // Active high drive levels
    always_comb begin
        leg.high = (st_ff == LEG_HIGH) && !hold_off;
        leg.low = (st_ff == LEG_LOW) && !hold_off;
    end

    // Counts cycles since either gate command was last on
    logic [CNT_W-1:0] gap_ff;
    logic was_high_ff;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gap_ff <= {CNT_W{1'b1}}; // Idle leg counts as long off
            was_high_ff <= 1'b0;
        end else begin
            if (leg.high || leg.low) begin
                gap_ff <= '0;
                was_high_ff <= leg.high;
            end else if (gap_ff != {CNT_W{1'b1}}) begin
                gap_ff <= gap_ff + CNT_W'(1);
            end
        end
    end

    property p_no_shoot;
        @(posedge clock) disable iff (sys_rst) !(leg.high && leg.low);
    endproperty
    a_no_shoot: assert property (p_no_shoot) else $error("both gates on");

    property p_dead_gap;
        @(posedge clock) disable iff (sys_rst)
            ($rose(leg.low) && was_high_ff) |-> gap_ff >= CNT_W'(DEAD - 1);
    endproperty
    a_dead_gap: assert property (p_dead_gap) else $error("side swap too fast");

    property p_dead_time;
        @(posedge clock) disable iff (sys_rst)
            ($rose(leg.high) || $rose(leg.low)) |-> (gap_ff >= CNT_W'(DEAD - 1) || $past(sys_rst));
    endproperty
    a_dead_time: assert property (p_dead_time) else $error("dead time short");

    property p_min_on;
        @(posedge clock) disable iff (sys_rst || hold_off)
            $rose(leg.high) |-> leg.high [*2];
    endproperty
    a_min_on: assert property (p_min_on) else $error("on pulse short");

    property p_min_off;
        @(posedge clock) disable iff (sys_rst)
            $fell(leg.high) |-> !leg.high [*8];
    endproperty
    a_min_off: assert property (p_min_off) else $error("off pulse short");
endmodule : igp_leg

// File: hdl/igp_ctrl.sv
/*
 Controller that drives the six gate commands of a three-phase module and watches
 its open-drain fault line. Assumes a pull-up on the fault wire and synchronous pins.
*/
`timescale 1ns/1ns
module igp_ctrl
    import igp_pkg::*;
#(
    parameter int FAULT_MIN = FAULT_MIN_CYC,
    parameter int DEAD = DEAD_CYC
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic [PHASES-1:0] REQ_HIGH,
    input wire logic [PHASES-1:0] REQ_LOW,
    input wire logic HI_CURRENT,
    input wire logic ENABLE,
    input wire logic FAULT_ACK,
    input wire logic FAULT_OUT_IN,
    output logic FAULT_OUT_OUT,
    output logic FAULT_OUT_OE,
    output logic [PHASES-1:0] HIGH_CMD,
    output logic [PHASES-1:0] LOW_CMD,
    output logic FAULT_SEEN,
    output logic FAULT_LATCHED
);
    logic fault_n_ff, nxt_fault_n;
    logic latch_ff, nxt_latch;
    logic [CNT_W-1:0] fcnt_ff, nxt_fcnt;
    logic hold_off;
    igp_leg_t legs [PHASES];
    logic [PHASES-1:0] hi_ff, nxt_hi, lo_ff, nxt_lo;

    // Fault pin is never driven; pulled up when released
    assign FAULT_OUT_OUT = 1'b0;
    assign FAULT_OUT_OE = 1'b0;

    // Fault latch and low-time measure up to the least pulse; set beats acknowledge
    always_comb begin
        nxt_fault_n = FAULT_OUT_IN;
        nxt_latch = latch_ff;
        nxt_fcnt = fcnt_ff;
        if (!FAULT_OUT_IN) begin
            nxt_latch = 1'b1;
            if (fcnt_ff < CNT_W'(FAULT_MIN)) begin
                nxt_fcnt = fcnt_ff + CNT_W'(1);
            end
        end else begin
            nxt_fcnt = '0;
            if (FAULT_ACK) begin
                nxt_latch = 1'b0;
            end
        end
    end

    // Fault registers
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            fault_n_ff <= 1'b1;
            latch_ff <= 1'b0;
            fcnt_ff <= '0;
        end else begin
            fault_n_ff <= nxt_fault_n;
            latch_ff <= nxt_latch;
            fcnt_ff <= nxt_fcnt;
        end
    end

    // Commands held off while fault stands or before acknowledge
    assign hold_off = !ENABLE || !fault_n_ff || latch_ff;
    assign FAULT_SEEN = !fault_n_ff;
    assign FAULT_LATCHED = latch_ff;

    // One shaper per phase
    genvar g;
    generate
        for (g = 0; g < PHASES; g++) begin : g_leg
            igp_leg #(
                .DEAD(DEAD),
                .MIN_ON(MIN_ON_CYC),
                .MIN_OFF(MIN_OFF_CYC)
            ) u_leg (
                .clock(CLOCK),
                .sys_rst(SYS_RST),
                .req_high(REQ_HIGH[g]),
                .req_low(REQ_LOW[g]),
                .hold_off(hold_off),
                .hi_current(HI_CURRENT),
                .leg(legs[g])
            );
            // Gate drive next values; zero under hold-off, edge restarts after
            always_comb begin
                nxt_hi[g] = legs[g].high && !hold_off;
                nxt_lo[g] = legs[g].low && !hold_off;
            end
        end
    endgenerate

    // Registered command pins
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            hi_ff <= '0;
            lo_ff <= '0;
        end else begin
            hi_ff <= nxt_hi;
            lo_ff <= nxt_lo;
        end
    end
    assign HIGH_CMD = hi_ff;
    assign LOW_CMD = lo_ff;

    // Relations between the fault line, enable and the commands
    property p_fault_blocks;
        @(posedge CLOCK) disable iff (SYS_RST)
            !FAULT_OUT_IN |-> ##2 (LOW_CMD == '0 && HIGH_CMD == '0);
    endproperty
    a_fault_blocks: assert property (p_fault_blocks) else $error("cmd during fault");

    property p_latch_holds;
        @(posedge CLOCK) disable iff (SYS_RST)
            (latch_ff && !FAULT_ACK) |=> latch_ff;
    endproperty
    a_latch_holds: assert property (p_latch_holds) else $error("latch lost");

    property p_latch_set;
        @(posedge CLOCK) disable iff (SYS_RST)
            !FAULT_OUT_IN |=> latch_ff;
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("fault not latched");

    property p_count_run;
        @(posedge CLOCK) disable iff (SYS_RST)
            (!FAULT_OUT_IN && fcnt_ff < CNT_W'(FAULT_MIN))
                |=> fcnt_ff == $past(fcnt_ff) + CNT_W'(1);
    endproperty
    a_count_run: assert property (p_count_run) else $error("fault count stuck");

    property p_pin_released;
        @(posedge CLOCK) disable iff (SYS_RST) !FAULT_OUT_OE;
    endproperty
    a_pin_released: assert property (p_pin_released) else $error("fault pin driven");

    property p_no_fight;
        @(posedge CLOCK) disable iff (SYS_RST) (HIGH_CMD & LOW_CMD) == '0;
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("leg shoot through");

    property p_disable;
        @(posedge CLOCK) disable iff (SYS_RST)
            !ENABLE |-> ##2 (HIGH_CMD == '0 && LOW_CMD == '0);
    endproperty
    a_disable: assert property (p_disable) else $error("cmd while disabled");
endmodule : igp_ctrl

// File: test/igp_dev_model.sv
/*
 Behavioural model of the power module seen by the gate controller.
 Assumes commands and fault causes change off the rising edge; the fault pin sinks only.
*/
`timescale 1ns/1ns
module igp_dev_model
    import igp_pkg::*;
#(
    parameter int FAULT_W = 50
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [PHASES-1:0] high_cmd,
    input wire logic [PHASES-1:0] low_cmd,
    input wire logic short_trip,
    input wire logic supply_undervolt,
    input wire logic [PHASES-1:0] boot_undervolt,
    output logic [PHASES-1:0] gate_high,
    output logic [PHASES-1:0] gate_low,
    output logic fault_sink
);
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [PHASES-1:0] arm_hi_ff, nxt_arm_hi, arm_lo_ff, nxt_arm_lo, hi_q_ff, lo_q_ff;

    // Fault pulse timer, reloaded by a trip or held by low supply
    always_comb begin
        nxt_cnt = (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
        if (short_trip || supply_undervolt) begin
            nxt_cnt = CNT_W'(FAULT_W);
        end
    end
    assign fault_sink = (cnt_ff != '0) || supply_undervolt;

    // Legs re-arm only on a fresh rising command
    always_comb begin
        nxt_arm_lo = arm_lo_ff | (low_cmd & ~lo_q_ff);
        if (fault_sink || short_trip) begin
            nxt_arm_lo = '0;
        end
        nxt_arm_hi = (arm_hi_ff | (high_cmd & ~hi_q_ff)) & ~boot_undervolt;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_ff <= '0;
            arm_hi_ff <= '0;
            arm_lo_ff <= '0;
            hi_q_ff <= '0;
            lo_q_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
            arm_hi_ff <= nxt_arm_hi;
            arm_lo_ff <= nxt_arm_lo;
            hi_q_ff <= high_cmd;
            lo_q_ff <= low_cmd;
        end
    end

    // Active-high gates; short pulses are passed, never stretched
    assign gate_low = low_cmd & arm_lo_ff & {PHASES{~fault_sink & ~short_trip}};
    assign gate_high = high_cmd & arm_hi_ff & ~boot_undervolt;
endmodule : igp_dev_model

// File: test/igp_ctrl_test.sv
/*
 Self-checking bench for the gate controller with a module model on its pins.
 Assumes the open-drain fault wire is pulled up here; inputs change on falling edges.
*/
`timescale 1ns/1ns
module igp_ctrl_test;
    import igp_pkg::*;
    localparam int FW = 50;
    logic clock = 0, sys_rst = 1, hi_cur = 0, enable = 1, ack = 0, sc = 0, uv = 0;
    logic [PHASES-1:0] req_hi = '0, req_lo = '0, boot_uv = '0, hcmd, lcmd, g_hi, g_lo;
    logic f_oe, f_out, f_seen, f_lat, sink, f_wire;
    logic [PHASES-1:0] prev = '0, cut = '1;
    int n_errors = 0, checked = 0;
    int on_n [PHASES], off_n [PHASES];

    always #2 clock = ~clock;
    // Pulled-up fault wire
    assign f_wire = (sink || (f_oe && !f_out)) ? 1'b0 : 1'b1;

    igp_ctrl #(.FAULT_MIN(FW), .DEAD(4)) i_igp_ctrl (.CLOCK(clock), .SYS_RST(sys_rst),
        .REQ_HIGH(req_hi), .REQ_LOW(req_lo), .HI_CURRENT(hi_cur), .ENABLE(enable),
        .FAULT_ACK(ack), .FAULT_OUT_IN(f_wire), .FAULT_OUT_OUT(f_out), .FAULT_OUT_OE(f_oe),
        .HIGH_CMD(hcmd), .LOW_CMD(lcmd), .FAULT_SEEN(f_seen), .FAULT_LATCHED(f_lat));
    igp_dev_model #(.FAULT_W(FW)) i_igp_dev_model (.clock(clock), .rst(sys_rst),
        .high_cmd(hcmd), .low_cmd(lcmd), .short_trip(sc), .supply_undervolt(uv),
        .boot_undervolt(boot_uv), .gate_high(g_hi), .gate_low(g_lo), .fault_sink(sink));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    // Bounded wait for one gate command to reach a level
    task automatic wait_cmd(input int p, input bit hi, input logic v);
        int n;
        n = 0;
        while ((hi ? hcmd[p] : lcmd[p]) !== v) begin
            @(negedge clock);
            n++;
            if (n > 2000) begin
                n_errors++;
                complete_run();
            end
        end
    endtask : wait_cmd

    // One on-pulse on one leg, request held until taken
    task automatic pulse(input int p, input bit hi, input int hold);
        if (hi) req_hi[p] = 1'b1;
        else req_lo[p] = 1'b1;
        wait_cmd(p, hi, 1'b1);
        check("other_side", {31'h0, hi ? lcmd[p] : hcmd[p]}, 32'h0);
        repeat (hold) @(negedge clock);
        req_hi[p] = 1'b0;
        req_lo[p] = 1'b0;
        wait_cmd(p, hi, 1'b0);
    endtask : pulse

    // Short circuit or low-supply dip while legs conduct, then re-arm
    task automatic trip(input bit low_dip, input int len);
        int n;
        req_lo[0] = 1'b1;
        req_hi[1] = 1'b1;
        wait_cmd(0, 0, 1'b1);
        wait_cmd(1, 1, 1'b1);
        if (low_dip) uv = 1'b1;
        else sc = 1'b1;
        repeat (len) @(negedge clock);
        uv = 1'b0;
        sc = 1'b0;
        repeat (4) @(negedge clock);
        check("cmds_cut", {26'h0, hcmd, lcmd}, 32'h0);
        check("pin_released", {30'h0, f_oe, f_out}, 32'h0);
        n = len + 4;
        while (f_seen === 1'b1 && n < 1000) begin
            @(negedge clock);
            n++;
        end
        check("fault_width", 32'(n >= FW + 1 && n >= len && n <= FW + len + 3), 32'h1);
        repeat (20) @(negedge clock);
        check("refused", {25'h0, f_lat, hcmd, lcmd}, 32'h40);
        req_lo[0] = 1'b0;
        req_hi[1] = 1'b0;
        ack = 1'b1;
        @(negedge clock);
        ack = 1'b0;
        @(negedge clock);
        check("unlatched", {31'h0, f_lat}, 32'h0);
        req_lo[0] = 1'b1;
        wait_cmd(0, 0, 1'b1);
        @(negedge clock);
        check("fresh_on", {31'h0, g_lo[0]}, 32'h1);
        req_lo[0] = 1'b0;
        wait_cmd(0, 0, 1'b0);
    endtask : trip

    // Leg timing monitor: shoot-through, least on time, least off time
    always @(posedge clock) begin
        if (!sys_rst) begin
            for (int i = 0; i < PHASES; i++) begin
                if (!enable || !f_wire || f_lat) cut[i] = 1'b1;
                check("shoot_through", {31'h0, hcmd[i] & lcmd[i]}, 32'h0);
                if (hcmd[i] | lcmd[i]) begin
                    if (!prev[i] && !cut[i]) check("off_time", 32'(off_n[i] >=
                        (hi_cur ? MIN_OFF_HI_CYC : MIN_OFF_CYC)), 32'h1);
                    if (!prev[i]) cut[i] = 1'b0;
                    on_n[i]++;
                    off_n[i] = 0;
                end else begin
                    if (prev[i] && !cut[i]) check("on_time", 32'(on_n[i] >= MIN_ON_CYC), 32'h1);
                    off_n[i]++;
                    on_n[i] = 0;
                end
                prev[i] = hcmd[i] | lcmd[i];
            end
        end
    end

    initial begin
        int p;
        p = $urandom(27);
        repeat (3) @(negedge clock);
        sys_rst = 1'b0;
        check("reset_state", {24'h0, f_seen, f_lat, hcmd, lcmd}, 32'h0);
        // Random legs and sides, every fourth a 3-cycle request
        for (int k = 0; k < 24; k++) begin
            if (k == 12) begin
                repeat (800) @(negedge clock);
                hi_cur = 1'b1;
            end
            p = $urandom % PHASES;
            pulse(p, 1'($urandom % 2), (k % 4 == 0) ? 3 : 20 + $urandom % 300);
        end
        // Both sides asked at once means leg off
        req_hi[2] = 1'b1;
        req_lo[2] = 1'b1;
        repeat (10) @(negedge clock);
        check("both_req", {30'h0, hcmd[2], lcmd[2]}, 32'h0);
        req_hi[2] = 1'b0;
        req_lo[2] = 1'b0;
        // Disable cuts a running leg
        req_lo[0] = 1'b1;
        wait_cmd(0, 0, 1'b1);
        enable = 1'b0;
        repeat (3) @(negedge clock);
        check("disabled", {31'h0, lcmd[0]}, 32'h0);
        enable = 1'b1;
        req_lo[0] = 1'b0;
        repeat (800) @(negedge clock);
        // Bootstrap dip: high gate dropped by module, no fault seen
        req_hi[1] = 1'b1;
        wait_cmd(1, 1, 1'b1);
        boot_uv[1] = 1'b1;
        repeat (20) @(negedge clock);
        check("boot_dip", {29'h0, g_hi[1], f_seen, f_lat}, 32'h0);
        boot_uv[1] = 1'b0;
        req_hi[1] = 1'b0;
        wait_cmd(1, 1, 1'b0);
        repeat (800) @(negedge clock);
        trip(1'b0, 1);
        trip(1'b1, 10);
        trip(1'b1, 100);
        complete_run();
    end
endmodule : igp_ctrl_test
